// ### verilog/cmvt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmvt_params.svh"
// mode register, call timing, vector and table address control
// the mode register sits at one data memory address and reads back
// combinationally, so a read needs no wait state
// calls are timed by a down counter loaded at the taking edge; the mode
// is sampled there, so a write during a call only affects the next one
// the vector fetcher is shared by the reset slot and all interrupt slots;
// an interrupt request is only taken while no fetch is running
// limitation: requests before the reset vector is fetched are ignored
module cmvt_top (
   input wire logic clk_i,
   input wire logic reset_n_i,
   // 4-bit data memory write/read port
   input wire logic mem_wr_i,
   input wire logic [11:0] mem_addr_i,
   input wire logic [3:0] mem_wdata_i,
   output logic [3:0] mem_rdata_o,
   // call request
   input wire logic call_req_i,
   input wire cmvt_pkg::cmvt_call_type call_kind_i,
   output logic call_busy_o,
   output logic call_done_o,
   output logic call_refused_o,
   output logic [1:0] push_bytes_o,
   output logic [2:0] call_cycles_o,
   // long branch legality query
   input wire logic long_branch_i,
   output logic long_branch_ok_o,
   // vector request
   input wire logic irq_req_i,
   input wire cmvt_pkg::cmvt_irq_type irq_src_i,
   input wire logic [7:0] rom_data_i,
   output logic [12:0] rom_addr_o,
   output logic vec_valid_o,
   output cmvt_pkg::cmvt_vector_type vec_o,
   // table-indirect
   input wire logic [5:0] table_indirect_instr_index_i,
   output logic [12:0] table_indirect_instr_addr_o,
   // indexed branch
   input wire logic idx_branch_i,
   input wire logic [12:0] pc_i,
   input wire logic [7:0] idx_i,
   output logic [12:0] idx_pc_o,
   // status
   output logic extended_mode_o,
   output logic stack_bank_o
);
   // top-level sequencing: the reset vector is fetched before anything runs
   typedef enum logic [1:0] {
      cmvt_boot, // first edge after reset: kick the reset vector fetch
      cmvt_boot_wait, // waiting for the fetcher to hand back the vector
      cmvt_run // normal operation, register writes and calls accepted
   } cmvt_state_type;
   // every register of this block lives in one struct
   typedef struct packed {
      // sequencing state
      cmvt_state_type state;
      // mode register: bit 3 mode, bit 2 reserved, bit 0 stack bank
      logic [3:0] sms;
      // machine cycles still to run in the current call
      logic [2:0] cyc_left;
      // total machine cycles of the last call
      logic [2:0] cyc_total;
      // stack bytes pushed by the last call
      logic [1:0] push;
      // one-cycle pulse: call finished
      logic call_done;
      // one-cycle pulse: call refused in this mode
      logic refused;
      // one-cycle pulse: vector word valid
      logic vec_valid;
      // last fetched vector, held until the next fetch ends
      cmvt_pkg::cmvt_vector_type vec;
      // spliced target of the last indexed branch
      logic [12:0] idx_pc;
   } cmvt_type;
   cmvt_type r; // current state
   cmvt_type next_r; // value for the next edge
   logic vf_start; // one-cycle request to the vector fetcher
   logic [12:0] vf_base; // even address of the vector slot to read
   logic vf_busy; // fetcher still walking its two bytes
   logic vf_done; // fetcher result pulse
   cmvt_pkg::cmvt_vector_type vf_vec; // fetcher result word
   logic is_ext; // decoded mode, high in extended mode

   // mode bit 0 means extended [RULE_01]
   assign is_ext = ~r.sms[`CMVT_MODE_BIT];

   // vector base: reset slot or interrupt slot by source order
   // each slot is two bytes, so the source code is doubled onto the base
   always_comb begin
      // default: no request, base points at the reset slot
      vf_start = 1'b0;
      vf_base = `CMVT_RESET_VEC; // [RULE_08]
      if (r.state == cmvt_boot) begin
         // one start pulse right after reset
         vf_start = 1'b1;
      end else if (r.state == cmvt_run && irq_req_i && !vf_busy) begin
         // an interrupt request is only taken while the fetcher is idle
         vf_start = 1'b1;
         vf_base = `CMVT_IRQ_VEC_BASE + {9'h000, irq_src_i, 1'b0}; // [RULE_09]
      end
   end

   // two-byte vector fetcher; its address goes straight to program memory
   // and its result is registered again below, so vec_o follows one edge later
   cmvt_vec_fetch u_vec_fetch (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .start_i(vf_start),
      .base_i(vf_base),
      .rom_data_i(rom_data_i),
      .rom_addr_o(rom_addr_o),
      .busy_o(vf_busy),
      .done_o(vf_done),
      .vec_o(vf_vec)
   );

   // next-state logic
   always_comb begin
      // hold everything, pulses drop back after one cycle
      next_r = r;
      next_r.call_done = 1'b0;
      next_r.refused = 1'b0;
      next_r.vec_valid = vf_done;
      // keep the fetched word until the next fetch ends
      if (vf_done) begin
         next_r.vec = vf_vec;
      end
      case (r.state)
         // fetcher starts this cycle, see the vector base logic
         cmvt_boot: next_r.state = cmvt_boot_wait;
         cmvt_boot_wait: begin
            // requests stay ignored until the reset vector is in
            if (vf_done) begin
               next_r.state = cmvt_run;
            end
         end
         cmvt_run: begin
            // register write; bit 2 forced to zero, bank codes 2/3 kept out
            // only bit 0 of the bank field is stored, so a prohibited code
            // folds onto bank 0 or 1 instead of pointing nowhere
            if (mem_wr_i && mem_addr_i == `CMVT_SMS_ADDR) begin // [RULE_04]
               next_r.sms = {mem_wdata_i[3], 1'b0, 1'b0, mem_wdata_i[0]}; // [RULE_03]
            end
            // call timing counter; mode sampled at call start [RULE_12]
            if (r.cyc_left != 3'h0) begin
               // call in progress: count down, pulse done on the last cycle
               next_r.cyc_left = r.cyc_left - 3'h1;
               if (r.cyc_left == 3'h1) begin
                  next_r.call_done = 1'b1;
               end
            end else if (call_req_i) begin
               // new call: push count and length follow the current mode
               // a refused call still updates both; they only mean
               // something together with a done pulse
               next_r.push = is_ext ? `CMVT_PUSH_EXT : `CMVT_PUSH_LEGACY; // [RULE_05]
               case (call_kind_i)
                  // absolute call
                  cmvt_pkg::cmvt_call_abs: begin
                     next_r.cyc_total = is_ext ? `CMVT_LONG_ABSOLUTE_CALL_CYC_EXT :
                        `CMVT_LONG_ABSOLUTE_CALL_CYC_LEG; // [RULE_07]
                  end
                  // fast call
                  cmvt_pkg::cmvt_call_fast: begin
                     next_r.cyc_total = is_ext ? `CMVT_FAST_CALL_CYC_EXT :
                        `CMVT_FAST_CALL_CYC_LEG; // [RULE_07]
                  end
                  // long call exists only in extended mode, timed like abs there
                  default: begin
                     next_r.cyc_total = `CMVT_LONG_ABSOLUTE_CALL_CYC_EXT;
                  end
               endcase
               if (call_kind_i == cmvt_pkg::cmvt_call_long && !is_ext) begin
                  // no counter load, so busy never rises for it
                  next_r.refused = 1'b1; // [RULE_06]
               end else begin
                  next_r.cyc_left = next_r.cyc_total;
               end
            end
            // indexed branch keeps upper pc bits
            if (idx_branch_i) begin
               next_r.idx_pc = {pc_i[12:8], idx_i}; // [RULE_11]
            end
         end
         // unused code: restart the boot sequence
         default: next_r.state = cmvt_boot;
      endcase
   end

   // state register; reset lands in legacy mode
   // the whole struct clears, then the mode register takes its reset code
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '0;
         r.sms <= `CMVT_SMS_RESET; // [RULE_02]
      end else begin
         r <= next_r;
      end
   end

   // register read is combinational; other addresses read as zero
   assign mem_rdata_o = (mem_addr_i == `CMVT_SMS_ADDR) ? r.sms : 4'h0;
   // busy is a straight decode of the counter, no extra flop
   assign call_busy_o = (r.cyc_left != 3'h0);
   assign call_done_o = r.call_done;
   assign call_refused_o = r.refused;
   // push count and length stand until the next call
   assign push_bytes_o = r.push;
   assign call_cycles_o = r.cyc_total;
   // query answered in the same cycle
   assign long_branch_ok_o = long_branch_i & is_ext; // [RULE_06]
   // vector pulse and held word
   assign vec_valid_o = r.vec_valid;
   assign vec_o = r.vec;
   // table entries two bytes each from the table base [RULE_10]
   // an index of 48 or more runs past the table end; callers keep below it
   assign table_indirect_instr_addr_o = `CMVT_TABLE_INDIRECT_INSTR_BASE + {6'h00, table_indirect_instr_index_i, 1'b0};
   // registered indexed branch target
   assign idx_pc_o = r.idx_pc;
   // status for the rest of the cpu
   assign extended_mode_o = is_ext;
   assign stack_bank_o = r.sms[0]; // [RULE_03]
endmodule : cmvt_top
`default_nettype wire

// ### verilog/cmvt_params.svh
// Function
// RULE_01 - bit 3 selects mode, 1 legacy
// RULE_02 - reset sets mode bit to legacy
// RULE_03 - low bits pick stack bank 0/1
// RULE_04 - written by 4-bit op, bit2 zero
// RULE_05 - call pushes 2 or 3 bytes
// RULE_06 - long branch/call only in extended mode
// RULE_07 - call cycle counts depend on mode
// RULE_08 - reset vector at 0000h-0001h, flags+address
// RULE_09 - interrupt vectors 0002h-000dh in order
// RULE_10 - table-indirect entries at 0020h-007fh
// RULE_11 - indexed branches replace low 8 pc bits
// RULE_12 - mode change affects later calls
`ifndef CMVT_PARAMS_SVH
`define CMVT_PARAMS_SVH
`define CMVT_SMS_ADDR 12'hf84
`define CMVT_SMS_RESET 4'h8
`define CMVT_MODE_BIT 3
`define CMVT_RSVD_BIT 2
`define CMVT_RESET_VEC 13'h0000
`define CMVT_IRQ_VEC_BASE 13'h0002
`define CMVT_TABLE_INDIRECT_INSTR_BASE 13'h0020
`define CMVT_TABLE_INDIRECT_INSTR_LAST 13'h007f
`define CMVT_MBE_BIT 7
`define CMVT_RBE_BIT 6
`define CMVT_PUSH_LEGACY 2'h2
`define CMVT_PUSH_EXT 2'h3
`define CMVT_LONG_ABSOLUTE_CALL_CYC_LEG 3'h3
`define CMVT_LONG_ABSOLUTE_CALL_CYC_EXT 3'h4
`define CMVT_FAST_CALL_CYC_LEG 3'h2
`define CMVT_FAST_CALL_CYC_EXT 3'h3
`endif

// ### verilog/cmvt_pkg.sv
`default_nettype none
package cmvt_pkg;
   // call kinds the sequencer can be asked to time
   typedef enum logic [1:0] {
      cmvt_call_abs,
      cmvt_call_fast,
      cmvt_call_long
   } cmvt_call_type;
   // vector source, interrupt order follows slot order
   typedef enum logic [2:0] {
      cmvt_src_timer_ext,
      cmvt_src_ext_a,
      cmvt_src_ext_b,
      cmvt_src_serial,
      cmvt_src_timer_a,
      cmvt_src_timer_b
   } cmvt_irq_type;
   // result of a vector fetch
   typedef struct packed {
      logic memory_bank_enable_flag;
      logic register_bank_enable_flag;
      logic [12:0] start_addr;
   } cmvt_vector_type;
endpackage : cmvt_pkg
`default_nettype wire

// ### verilog/cmvt_vec_fetch.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmvt_params.svh"
// two-byte vector fetcher: high byte at even address, low byte next
module cmvt_vec_fetch (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic start_i,
   input wire logic [12:0] base_i,
   input wire logic [7:0] rom_data_i,
   output logic [12:0] rom_addr_o,
   output logic busy_o,
   output logic done_o,
   output cmvt_pkg::cmvt_vector_type vec_o
);
   typedef enum logic [1:0] {
      cmvt_vf_idle,
      cmvt_vf_high,
      cmvt_vf_low
   } cmvt_vf_state_type;
   typedef struct packed {
      cmvt_vf_state_type state;
      logic [12:0] addr;
      logic [7:0] high;
      logic done;
      cmvt_pkg::cmvt_vector_type vec;
   } cmvt_vf_type;
   cmvt_vf_type r;
   cmvt_vf_type next_r;

   // rom answers in the same cycle in which the address is presented
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      case (r.state)
         cmvt_vf_idle: begin
            if (start_i) begin
               next_r.addr = base_i;
               next_r.state = cmvt_vf_high;
            end
         end
         cmvt_vf_high: begin
            // flags sit in the high byte [RULE_08]
            next_r.high = rom_data_i;
            next_r.addr = r.addr + 13'h0001;
            next_r.state = cmvt_vf_low;
         end
         cmvt_vf_low: begin
            next_r.vec.memory_bank_enable_flag = r.high[`CMVT_MBE_BIT]; // [RULE_08]
            next_r.vec.register_bank_enable_flag = r.high[`CMVT_RBE_BIT]; // [RULE_08]
            next_r.vec.start_addr = {r.high[4:0], rom_data_i};
            next_r.done = 1'b1;
            next_r.state = cmvt_vf_idle;
         end
         default: next_r.state = cmvt_vf_idle;
      endcase
   end

   // state register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign rom_addr_o = r.addr;
   assign busy_o = (r.state != cmvt_vf_idle);
   assign done_o = r.done;
   assign vec_o = r.vec;
endmodule : cmvt_vec_fetch
`default_nettype wire

// ### sim/cmvt_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
// program memory stand-in; the fetcher registers its own address, so the
// byte is answered in the same cycle in which that address stands
module cmvt_rom_model (
   input wire logic [12:0] addr_i,
   output logic [7:0] data_o
);
   // one pattern for all slots; low slots keep bit 5 clear
   // upper address bits fold in so that every address bit is used
   assign data_o = addr_i[7:0] ^ 8'h5a ^ {3'h0, addr_i[12:8]};
endmodule : cmvt_rom_model
`default_nettype wire

// ### sim/cmvt_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// watches mode register, call, query and address ports
module cmvt_top_monitor (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [11:0] mem_addr_i,
   input wire logic [3:0] mem_rdata_o,
   input wire logic mem_wr_i,
   input wire logic [3:0] mem_wdata_i,
   input wire logic vec_valid_o,
   input wire logic extended_mode_o,
   input wire logic stack_bank_o,
   input wire logic call_req_i,
   input wire cmvt_pkg::cmvt_call_type call_kind_i,
   input wire logic call_busy_o,
   input wire logic call_done_o,
   input wire logic call_refused_o,
   input wire logic [1:0] push_bytes_o,
   input wire logic long_branch_i,
   input wire logic long_branch_ok_o,
   input wire logic [5:0] table_indirect_instr_index_i,
   input wire logic [12:0] table_indirect_instr_addr_o,
   input wire logic idx_branch_i,
   input wire logic [12:0] pc_i,
   input wire logic [7:0] idx_i,
   input wire logic [12:0] idx_pc_o
);
   logic [12:0] exp_pc; // target spliced from pc_i and idx_i at the last edge
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // keep the spliced target one edge ahead
   always_ff @(posedge clk_i) begin
      exp_pc <= {pc_i[12:8], idx_i};
   end
   a_mode_bit: assert property (
      mem_addr_i == 12'hf84 |-> extended_mode_o == !mem_rdata_o[3])
      else $error("mode output wrong");
   a_mode_write: assert property (
      mem_wr_i && mem_addr_i == 12'hf84 |=> extended_mode_o == !$past(mem_wdata_i[3]))
      else $error("mode write not applied");
   a_reset_legacy: assert property (
      $rose(reset_n_i) |-> !extended_mode_o ##1 !extended_mode_o)
      else $error("not legacy after reset");
   a_stack_bank: assert property (
      mem_addr_i == 12'hf84 |-> stack_bank_o == mem_rdata_o[0])
      else $error("stack bank wrong");
   a_push_mode: assert property (
      call_done_o |-> push_bytes_o == (extended_mode_o ? 2'h3 : 2'h2))
      else $error("push count wrong");
   a_branch_query: assert property (
      long_branch_ok_o == (long_branch_i && extended_mode_o))
      else $error("long branch answer wrong");
   a_long_refused: assert property (
      call_req_i && !call_busy_o && call_kind_i == cmvt_pkg::cmvt_call_long
      && !extended_mode_o |=> call_refused_o && !call_done_o)
      else $error("long call not refused");
   a_table_addr: assert property (
      table_indirect_instr_index_i < 6'h30 |-> table_indirect_instr_addr_o == 13'h0020 + {6'h0, table_indirect_instr_index_i, 1'b0})
      else $error("table address wrong");
   a_index_target: assert property (
      idx_branch_i |=> idx_pc_o == exp_pc)
      else $error("indexed target wrong");
   cover property (call_refused_o);
   cover property (call_done_o && extended_mode_o);
   cover property (idx_branch_i);
   cover property (vec_valid_o);
endmodule : cmvt_top_monitor
bind cmvt_top cmvt_top_monitor mon_u (.*);
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// drives the mode block, queues expectations, checks pulses
module testbench;
   logic clk_i, reset_n_i, mem_wr_i, call_req_i, long_branch_i, irq_req_i;
   logic idx_branch_i, call_busy_o, call_done_o, call_refused_o, long_branch_ok_o;
   logic vec_valid_o, extended_mode_o, stack_bank_o;
   logic [11:0] mem_addr_i;
   logic [3:0] mem_wdata_i, mem_rdata_o, md;
   logic [7:0] rom_data_i, idx_i;
   logic [12:0] rom_addr_o, table_indirect_instr_addr_o, pc_i, idx_pc_o;
   logic [5:0] table_indirect_instr_index_i;
   logic [1:0] push_bytes_o;
   logic [2:0] call_cycles_o;
   cmvt_pkg::cmvt_call_type call_kind_i;
   cmvt_pkg::cmvt_irq_type irq_src_i;
   cmvt_pkg::cmvt_vector_type vec_o;
   logic [15:0] q[$]; // expected results, oldest first
   int err_total = 0, compares = 0, cyc = 0;
   cmvt_top dut_u (.*);
   cmvt_rom_model rom_u (.addr_i(rom_addr_o), .data_o(rom_data_i));
   task chk(input string n, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task conclude;
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // vector as the rom pattern should deliver it
   function automatic logic [15:0] ev(input logic [7:0] b);
      logic [7:0] h, l;
      h = b ^ 8'h5a;
      l = (b + 8'h01) ^ 8'h5a;
      return {1'b0, h[7], h[6], h[4:0], l};
   endfunction : ev
   // bounded wait for a result pulse, then step past it
   task wt;
      int i;
      for (i = 0; i < 20 && !(call_done_o | call_refused_o | vec_valid_o); i++)
         @(negedge clk_i);
      if (i == 20) err_total++;
      @(negedge clk_i);
   endtask : wt
   task wr(input logic [11:0] a, input logic [3:0] d);
      mem_addr_i = a;
      mem_wdata_i = d;
      mem_wr_i = 1'b1;
      @(negedge clk_i);
      mem_wr_i = 1'b0;
      mem_addr_i = 12'hf84;
      // idle edge so back-to-back writes never retoggle the strobe at once
      @(negedge clk_i);
   endtask : wr
   // one call; long in legacy must be refused
   task call(input cmvt_pkg::cmvt_call_type k, input logic x);
      if (k == cmvt_pkg::cmvt_call_long && !x)
         q.push_back(16'hffff);
      else
         q.push_back({11'h0, x ? 2'h3 : 2'h2, 3'(k == 1 ? 2 : 3) + 3'(x)});
      call_kind_i = k;
      call_req_i = 1'b1;
      @(negedge clk_i);
      chk("busy", 16'(call_busy_o), 16'(!(k == cmvt_pkg::cmvt_call_long && !x)));
      call_req_i = 1'b0;
      wt();
   endtask : call
   // pair each result pulse with the oldest note
   always @(negedge clk_i) begin
      if (vec_valid_o)
         chk("vector", {1'b0, vec_o}, q.pop_front());
      if (call_done_o)
         chk("call", {11'h0, push_bytes_o, call_cycles_o}, q.pop_front());
      if (call_refused_o)
         chk("refuse", 16'hffff, q.pop_front());
   end
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // cut a hang short
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      {reset_n_i, mem_wr_i, call_req_i, long_branch_i, irq_req_i, idx_branch_i} = '0;
      {mem_wdata_i, table_indirect_instr_index_i, pc_i, idx_i} = '0;
      mem_addr_i = 12'hf84;
      call_kind_i = cmvt_pkg::cmvt_call_abs;
      irq_src_i = cmvt_pkg::cmvt_src_timer_ext;
      md = 4'($urandom(32'hb0aa7980));
      repeat (12) @(negedge clk_i);
      q.push_back(ev(8'h00));
      reset_n_i = 1'b1;
      wt();
      chk("reset", 16'(mem_rdata_o), 16'h0008);
      long_branch_i = 1'b1;
      // legacy, extended, legacy again; bit 2 written as 1
      for (int j = 0; j < 3; j++) begin
         md = {j != 1, 1'b1, 2'($urandom)};
         wr(12'hf84, md);
         wr(12'h100, ~md);
         chk("mode", 16'(mem_rdata_o), 16'({md[3], 2'b00, md[0]}));
         chk("ext", 16'(extended_mode_o), 16'(!md[3]));
         chk("bank", 16'(stack_bank_o), 16'(md[0]));
         chk("branch", 16'(long_branch_ok_o), 16'(!md[3]));
         for (int k = 0; k < 3; k++)
            call(cmvt_pkg::cmvt_call_type'(k), !md[3]);
      end
      for (int s = 0; s < 6; s++) begin
         irq_src_i = cmvt_pkg::cmvt_irq_type'(s);
         q.push_back(ev(8'(2 + 2 * s)));
         irq_req_i = 1'b1;
         @(negedge clk_i);
         irq_req_i = 1'b0;
         wt();
      end
      repeat (20) begin
         table_indirect_instr_index_i = 6'($urandom_range(47));
         pc_i = 13'($urandom);
         idx_i = 8'($urandom);
         idx_branch_i = 1'b1;
         #1;
         chk("table", 16'(table_indirect_instr_addr_o), 16'(13'h0020 + 13'(table_indirect_instr_index_i) * 2));
         @(negedge clk_i);
         chk("target", 16'(idx_pc_o), 16'({pc_i[12:8], idx_i}));
      end
      conclude();
   end
endmodule : testbench
`default_nettype wire
